// File: hdl/crtcx_pkg.sv
// Constants shared by the CRT controller extended timing register block
package crtcx_pkg;

  // Host port addresses, I/O and memory-mapped
  localparam logic [15:0] CRTCX_IDX_MONO_ADDR      = 16'h03B4;
  localparam logic [15:0] CRTCX_IDX_COLOUR_IO_ADDR = 16'h03D4;
  localparam logic [15:0] CRTCX_IDX_COLOUR_MM_ADDR = 16'h03D3;
  localparam logic [15:0] CRTCX_DATA_MONO_ADDR     = 16'h03B5;
  localparam logic [15:0] CRTCX_DATA_COLOUR_ADDR   = 16'h03D5;

  // Register indices
  localparam logic [7:0] CRTCX_IDX_BASE_HTOTAL   = 8'h00;
  localparam logic [7:0] CRTCX_IDX_HBLANK_END    = 8'h03;
  localparam logic [7:0] CRTCX_IDX_HRETRACE_END  = 8'h05;
  localparam logic [7:0] CRTCX_IDX_BASE_VTOTAL   = 8'h06;
  localparam logic [7:0] CRTCX_IDX_OVERFLOW      = 8'h07;
  localparam logic [7:0] CRTCX_IDX_MAX_SCAN      = 8'h09;
  localparam logic [7:0] CRTCX_IDX_BASE_VSYNC    = 8'h10;
  localparam logic [7:0] CRTCX_IDX_VRETRACE_END  = 8'h11;
  localparam logic [7:0] CRTCX_IDX_BASE_VDISP    = 8'h12;
  localparam logic [7:0] CRTCX_IDX_BASE_VBLANK   = 8'h15;
  localparam logic [7:0] CRTCX_IDX_EXT_VTOTAL    = 8'h30;
  localparam logic [7:0] CRTCX_IDX_EXT_VDISP     = 8'h31;
  localparam logic [7:0] CRTCX_IDX_EXT_VSYNC     = 8'h32;
  localparam logic [7:0] CRTCX_IDX_EXT_VBLANK    = 8'h33;
  localparam logic [7:0] CRTCX_IDX_EXT_HTOTAL    = 8'h35;
  localparam logic [7:0] CRTCX_IDX_EXT_HBLANK    = 8'h39;
  localparam logic [7:0] CRTCX_IDX_IO_CONTROL    = 8'h80;
  localparam logic [7:0] CRTCX_IDX_PROTECT_LAST  = 8'h07;

  // Field positions
  localparam int CRTCX_PROTECT_BIT    = 7;
  localparam int CRTCX_EXT_ENABLE_BIT = 0;
  localparam int CRTCX_OVF_VT8        = 0;
  localparam int CRTCX_OVF_VDE8       = 1;
  localparam int CRTCX_OVF_VSS8       = 2;
  localparam int CRTCX_OVF_VBS8       = 3;
  localparam int CRTCX_OVF_VT9        = 5;
  localparam int CRTCX_OVF_VDE9       = 6;
  localparam int CRTCX_OVF_VSS9       = 7;
  localparam int CRTCX_MSL_VBS9       = 5;
  localparam int CRTCX_HRE_HBE5       = 7;

  // Write masks and reset value
  localparam logic [7:0] CRTCX_EXT_V_MASK  = 8'h0F;
  localparam logic [7:0] CRTCX_EXT_H_MASK  = 8'h01;
  localparam logic [7:0] CRTCX_IOCTL_MASK  = 8'h03;
  localparam logic [7:0] CRTCX_REG_RESET   = 8'h00;

endpackage

// File: hdl/crtcx_match_if.sv
// Interface between the register block and a scan-line comparator
`timescale 1ns/1ps
interface crtcx_match_if #(
  parameter int VAL_W = 12
);
  logic [VAL_W-1:0] value;
  logic [VAL_W-1:0] line;
  logic             strobe;
  logic             hit;

  modport ctrl (output value, output line, output strobe, input hit);
  modport cmp  (input value, input line, input strobe, output hit);
endinterface

// File: hdl/crtcx_line_match.sv
// Scan-line comparator raising a one-cycle pulse on a programmed line
`timescale 1ns/1ps
module crtcx_line_match
  import crtcx_pkg::*;
#(
  parameter int VAL_W = 12
) (
  input  wire logic   clk_in,
  input  wire logic   rst_in,
  crtcx_match_if.cmp  m_if
);

  typedef struct packed {
    logic hit;
  } crtcx_lm_state_type;

  crtcx_lm_state_type st_r;
  crtcx_lm_state_type st_nxt;

  if (VAL_W < 12) begin : g_chk
    $error("crtcx_line_match: VAL_W must hold a 12-bit value");
  end

  always_comb begin
    st_nxt     = st_r;
    // Line numbers count from the first active line, which is line 0
    st_nxt.hit = m_if.strobe && (m_if.line == m_if.value);
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign m_if.hit = st_r.hit;

endmodule // crtcx_line_match

// File: hdl/crtcx_timing_regs.sv
// CRT controller index/data port with extended vertical and horizontal timing registers
`timescale 1ns/1ps
// Overview of operation
// - Index port at mono or colour address
// - Data port accesses register of latched index
// - Memory-mapped colour index sits at 3D3h
// - Retrace-end bit 7 blocks writes 0-7
// - Standard vertical total: overflow bits 5,0
// - Extended vertical total: upper nibble extension
// - Standard display end: overflow bits 6,1
// - Extended display end: upper nibble extension
// - Active area starts line 0; end=lines-1
// - Standard sync start: overflow bits 7,2
// - Extended sync start: upper nibble extension
// - Sync begins on line equal sync start
// - Standard blank start: scan bit5, overflow bit3
// - Extended blank start: upper nibble extension
// - Blanking begins on line equal blank start
// - Standard mode ignores extension nibbles
// - Extended vertical bits 7:4 read zero
// - Horizontal total gains extension bit 0 MSB
// - Blank end gains extension bit 0 MSB
module crtcx_timing_regs
  import crtcx_pkg::*;
#(
  parameter int VAL_W = 12
) (
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire logic              colour_emulation_in,
  input  wire logic              mem_space_in,
  input  wire logic [15:0]       addr_in,
  input  wire logic              wr_in,
  input  wire logic              rd_in,
  input  wire logic [7:0]        wdata_in,
  input  wire logic [VAL_W-1:0]  scan_line_in,
  input  wire logic              scan_line_strobe_in,
  output logic      [7:0]        rdata_out,
  output logic                   rvalid_out,
  output logic                   ext_mode_out,
  output logic      [VAL_W-1:0]  vtotal_out,
  output logic      [VAL_W-1:0]  vdisp_end_out,
  output logic      [VAL_W-1:0]  vsync_start_out,
  output logic      [VAL_W-1:0]  vblank_start_out,
  output logic      [8:0]        htotal_out,
  output logic      [6:0]        hblank_end_out,
  output logic                   vsync_begin_out,
  output logic                   vblank_begin_out
);

  if (VAL_W != 12) begin : g_chk
    $error("crtcx_timing_regs: VAL_W must be 12");
  end

  typedef struct packed {
    logic [7:0]       idx;
    logic [7:0]       base_horizontal_total;
    logic [7:0]       hblank_end_reg;
    logic [7:0]       hretrace_end_reg;
    logic [7:0]       base_vertical_total;
    logic [7:0]       timing_overflow;
    logic [7:0]       max_scan_line;
    logic [7:0]       base_vsync_start;
    logic [7:0]       vretrace_end_protect;
    logic [7:0]       base_vdisp_end;
    logic [7:0]       base_vblank_start;
    logic [7:0]       ext_vtotal_upper;
    logic [7:0]       ext_vdisp_end_upper;
    logic [7:0]       ext_vsync_start_upper;
    logic [7:0]       ext_vblank_start_upper;
    logic [7:0]       ext_htotal_top_bit;
    logic [7:0]       ext_hblank_top_bit;
    logic [7:0]       crtc_io_control;
    logic [7:0]       rdata;
    logic             rvalid;
    logic             ext_mode;
    logic [VAL_W-1:0] vtotal;
    logic [VAL_W-1:0] vdisp_end;
    logic [VAL_W-1:0] vsync_start;
    logic [VAL_W-1:0] vblank_start;
    logic [8:0]       htotal;
    logic [6:0]       hblank_end;
  } crtcx_state_type;

  crtcx_state_type st_r;
  crtcx_state_type st_nxt;

  crtcx_match_if #(.VAL_W(VAL_W)) vsync_if ();
  crtcx_match_if #(.VAL_W(VAL_W)) vblank_if ();

  // Address decode
  logic [15:0] idx_addr;
  logic        idx_sel;
  logic        data_sel;
  logic        idx_wr;
  logic        data_wr;
  logic        any_rd;
  logic        protected_idx;
  logic [7:0]  reg_rd;

  always_comb begin
    if (!colour_emulation_in) begin
      idx_addr = CRTCX_IDX_MONO_ADDR;
    end else if (mem_space_in) begin
      idx_addr = CRTCX_IDX_COLOUR_MM_ADDR;
    end else begin
      idx_addr = CRTCX_IDX_COLOUR_IO_ADDR;
    end
    idx_sel  = (addr_in == idx_addr);
    data_sel = (addr_in == (colour_emulation_in ? CRTCX_DATA_COLOUR_ADDR
                                                : CRTCX_DATA_MONO_ADDR));
    idx_wr   = wr_in && idx_sel;
    data_wr  = wr_in && data_sel;
    any_rd   = rd_in && (idx_sel || data_sel);
    // Only the base group 0-7 is lockable; no other group exists
    protected_idx = (st_r.idx <= CRTCX_IDX_PROTECT_LAST)
                    && st_r.vretrace_end_protect[CRTCX_PROTECT_BIT];
  end

  // Read mux; unmapped indices read as zero
  always_comb begin
    case (st_r.idx)
      CRTCX_IDX_BASE_HTOTAL:  reg_rd = st_r.base_horizontal_total;
      CRTCX_IDX_HBLANK_END:   reg_rd = st_r.hblank_end_reg;
      CRTCX_IDX_HRETRACE_END: reg_rd = st_r.hretrace_end_reg;
      CRTCX_IDX_BASE_VTOTAL:  reg_rd = st_r.base_vertical_total;
      CRTCX_IDX_OVERFLOW:     reg_rd = st_r.timing_overflow;
      CRTCX_IDX_MAX_SCAN:     reg_rd = st_r.max_scan_line;
      CRTCX_IDX_BASE_VSYNC:   reg_rd = st_r.base_vsync_start;
      CRTCX_IDX_VRETRACE_END: reg_rd = st_r.vretrace_end_protect;
      CRTCX_IDX_BASE_VDISP:   reg_rd = st_r.base_vdisp_end;
      CRTCX_IDX_BASE_VBLANK:  reg_rd = st_r.base_vblank_start;
      CRTCX_IDX_EXT_VTOTAL:   reg_rd = st_r.ext_vtotal_upper;
      CRTCX_IDX_EXT_VDISP:    reg_rd = st_r.ext_vdisp_end_upper;
      CRTCX_IDX_EXT_VSYNC:    reg_rd = st_r.ext_vsync_start_upper;
      CRTCX_IDX_EXT_VBLANK:   reg_rd = st_r.ext_vblank_start_upper;
      CRTCX_IDX_EXT_HTOTAL:   reg_rd = st_r.ext_htotal_top_bit;
      CRTCX_IDX_EXT_HBLANK:   reg_rd = st_r.ext_hblank_top_bit;
      CRTCX_IDX_IO_CONTROL:   reg_rd = st_r.crtc_io_control;
      default:                reg_rd = 8'h00;
    endcase
  end

  always_comb begin
    st_nxt        = st_r;
    st_nxt.rvalid = 1'b0;
    // Index is only replaced by an index-port write
    if (idx_wr) begin
      st_nxt.idx = wdata_in;
    end
    if (data_wr && !protected_idx) begin
      case (st_r.idx)
        CRTCX_IDX_BASE_HTOTAL:  st_nxt.base_horizontal_total = wdata_in;
        CRTCX_IDX_HBLANK_END:   st_nxt.hblank_end_reg        = wdata_in;
        CRTCX_IDX_HRETRACE_END: st_nxt.hretrace_end_reg      = wdata_in;
        CRTCX_IDX_BASE_VTOTAL:  st_nxt.base_vertical_total   = wdata_in;
        CRTCX_IDX_OVERFLOW:     st_nxt.timing_overflow       = wdata_in;
        CRTCX_IDX_MAX_SCAN:     st_nxt.max_scan_line         = wdata_in;
        CRTCX_IDX_BASE_VSYNC:   st_nxt.base_vsync_start      = wdata_in;
        CRTCX_IDX_VRETRACE_END: st_nxt.vretrace_end_protect  = wdata_in;
        CRTCX_IDX_BASE_VDISP:   st_nxt.base_vdisp_end        = wdata_in;
        CRTCX_IDX_BASE_VBLANK:  st_nxt.base_vblank_start     = wdata_in;
        // Reserved upper nibble is not stored, so it reads back zero
        CRTCX_IDX_EXT_VTOTAL:   st_nxt.ext_vtotal_upper       = wdata_in & CRTCX_EXT_V_MASK;
        CRTCX_IDX_EXT_VDISP:    st_nxt.ext_vdisp_end_upper    = wdata_in & CRTCX_EXT_V_MASK;
        CRTCX_IDX_EXT_VSYNC:    st_nxt.ext_vsync_start_upper  = wdata_in & CRTCX_EXT_V_MASK;
        CRTCX_IDX_EXT_VBLANK:   st_nxt.ext_vblank_start_upper = wdata_in & CRTCX_EXT_V_MASK;
        CRTCX_IDX_EXT_HTOTAL:   st_nxt.ext_htotal_top_bit     = wdata_in & CRTCX_EXT_H_MASK;
        CRTCX_IDX_EXT_HBLANK:   st_nxt.ext_hblank_top_bit     = wdata_in & CRTCX_EXT_H_MASK;
        CRTCX_IDX_IO_CONTROL:   st_nxt.crtc_io_control        = wdata_in & CRTCX_IOCTL_MASK;
        default: ;
      endcase
    end
    if (any_rd) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = idx_sel ? st_r.idx : reg_rd;
    end

    // Timing values follow the registers one cycle later
    st_nxt.ext_mode = st_r.crtc_io_control[CRTCX_EXT_ENABLE_BIT];
    if (st_r.crtc_io_control[CRTCX_EXT_ENABLE_BIT]) begin
      st_nxt.vtotal       = {st_r.ext_vtotal_upper[3:0], st_r.base_vertical_total};
      st_nxt.vdisp_end    = {st_r.ext_vdisp_end_upper[3:0], st_r.base_vdisp_end};
      st_nxt.vsync_start  = {st_r.ext_vsync_start_upper[3:0], st_r.base_vsync_start};
      st_nxt.vblank_start = {st_r.ext_vblank_start_upper[3:0], st_r.base_vblank_start};
    end else begin
      // Extension nibbles are dropped, upper two bits forced low
      st_nxt.vtotal       = {2'b00, st_r.timing_overflow[CRTCX_OVF_VT9],
                             st_r.timing_overflow[CRTCX_OVF_VT8], st_r.base_vertical_total};
      st_nxt.vdisp_end    = {2'b00, st_r.timing_overflow[CRTCX_OVF_VDE9],
                             st_r.timing_overflow[CRTCX_OVF_VDE8], st_r.base_vdisp_end};
      st_nxt.vsync_start  = {2'b00, st_r.timing_overflow[CRTCX_OVF_VSS9],
                             st_r.timing_overflow[CRTCX_OVF_VSS8], st_r.base_vsync_start};
      st_nxt.vblank_start = {2'b00, st_r.max_scan_line[CRTCX_MSL_VBS9],
                             st_r.timing_overflow[CRTCX_OVF_VBS8], st_r.base_vblank_start};
    end
    st_nxt.htotal     = {st_r.ext_htotal_top_bit[0], st_r.base_horizontal_total};
    st_nxt.hblank_end = {st_r.ext_hblank_top_bit[0], st_r.hretrace_end_reg[CRTCX_HRE_HBE5],
                         st_r.hblank_end_reg[4:0]};
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Line comparators; line 0 is the first active line
  assign vsync_if.value   = st_r.vsync_start;
  assign vsync_if.line    = scan_line_in;
  assign vsync_if.strobe  = scan_line_strobe_in;
  assign vblank_if.value  = st_r.vblank_start;
  assign vblank_if.line   = scan_line_in;
  assign vblank_if.strobe = scan_line_strobe_in;

  crtcx_line_match #(.VAL_W(VAL_W)) u_vsync_match (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .m_if   (vsync_if.cmp)
  );

  crtcx_line_match #(.VAL_W(VAL_W)) u_vblank_match (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .m_if   (vblank_if.cmp)
  );

  assign rdata_out        = st_r.rdata;
  assign rvalid_out       = st_r.rvalid;
  assign ext_mode_out     = st_r.ext_mode;
  assign vtotal_out       = st_r.vtotal;
  assign vdisp_end_out    = st_r.vdisp_end;
  assign vsync_start_out  = st_r.vsync_start;
  assign vblank_start_out = st_r.vblank_start;
  assign htotal_out       = st_r.htotal;
  assign hblank_end_out   = st_r.hblank_end;
  // Straight from the comparator flops
  assign vsync_begin_out  = vsync_if.hit;
  assign vblank_begin_out = vblank_if.hit;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_index_port_mono: assert property (
    (wr_in && !colour_emulation_in && addr_in == CRTCX_IDX_MONO_ADDR)
      |=> (st_r.idx == $past(wdata_in)))
    else $error("index not latched from mono index port");

  a_index_port_mm: assert property (
    (wr_in && colour_emulation_in && mem_space_in && addr_in == CRTCX_IDX_COLOUR_MM_ADDR)
      |=> (st_r.idx == $past(wdata_in)))
    else $error("index not latched from memory-mapped colour index port");

  a_index_hold: assert property (
    !(wr_in && idx_sel) |=> $stable(st_r.idx))
    else $error("index changed without index port write");

  a_read_answer: assert property (
    (rd_in && data_sel) |=> (rvalid_out && rdata_out == $past(reg_rd)))
    else $error("data port read did not return selected register");

  a_group0_lock: assert property (
    (wr_in && data_sel && st_r.vretrace_end_protect[7] && st_r.idx == CRTCX_IDX_BASE_VTOTAL)
      |=> $stable(st_r.base_vertical_total))
    else $error("protected register was written");

  a_vtotal_std: assert property (
    !st_r.crtc_io_control[0] |=> (vtotal_out ==
      {2'b00, $past(st_r.timing_overflow[5]), $past(st_r.timing_overflow[0]), $past(st_r.base_vertical_total)}))
    else $error("standard vertical total mis-assembled");

  a_vtotal_ext: assert property (
    st_r.crtc_io_control[0] |=> (vtotal_out ==
      {$past(st_r.ext_vtotal_upper[3:0]), $past(st_r.base_vertical_total)}))
    else $error("extended vertical total mis-assembled");

  a_vblank_std: assert property (
    !st_r.crtc_io_control[0] |=> (vblank_start_out ==
      {2'b00, $past(st_r.max_scan_line[5]), $past(st_r.timing_overflow[3]), $past(st_r.base_vblank_start)}))
    else $error("standard vertical blank start mis-assembled");

  a_std_ignores_ext: assert property (
    !ext_mode_out |-> (vdisp_end_out[11:10] == 2'b00 && vsync_start_out[11:10] == 2'b00))
    else $error("extension bits leaked into standard mode");

  a_resv_zero: assert property (
    (rd_in && data_sel && st_r.idx >= CRTCX_IDX_EXT_VTOTAL && st_r.idx <= CRTCX_IDX_EXT_VBLANK)
      |=> (rdata_out[7:4] == 4'h0))
    else $error("reserved extended bits read nonzero");

  a_sync_begin: assert property (
    (scan_line_strobe_in && scan_line_in == vsync_start_out) |=> vsync_begin_out)
    else $error("vertical sync did not begin on its line");

  a_hblank_msb: assert property (
    ##1 (hblank_end_out[6] == $past(st_r.ext_hblank_top_bit[0])))
    else $error("horizontal blank end top bit wrong");

  a_vdisp_std: assert property (
    !st_r.crtc_io_control[0] |=> (vdisp_end_out ==
      {2'b00, $past(st_r.timing_overflow[6]), $past(st_r.timing_overflow[1]), $past(st_r.base_vdisp_end)}))
    else $error("standard vertical display end mis-assembled");

  a_vdisp_ext: assert property (
    st_r.crtc_io_control[0] |=> (vdisp_end_out ==
      {$past(st_r.ext_vdisp_end_upper[3:0]), $past(st_r.base_vdisp_end)}))
    else $error("extended vertical display end mis-assembled");

  a_vsync_std: assert property (
    !st_r.crtc_io_control[0] |=> (vsync_start_out ==
      {2'b00, $past(st_r.timing_overflow[7]), $past(st_r.timing_overflow[2]), $past(st_r.base_vsync_start)}))
    else $error("standard vertical sync start mis-assembled");

  a_vsync_ext: assert property (
    st_r.crtc_io_control[0] |=> (vsync_start_out ==
      {$past(st_r.ext_vsync_start_upper[3:0]), $past(st_r.base_vsync_start)}))
    else $error("extended vertical sync start mis-assembled");

  a_vblank_ext: assert property (
    st_r.crtc_io_control[0] |=> (vblank_start_out ==
      {$past(st_r.ext_vblank_start_upper[3:0]), $past(st_r.base_vblank_start)}))
    else $error("extended vertical blank start mis-assembled");

  a_blank_begin: assert property (
    (scan_line_strobe_in && scan_line_in == vblank_start_out) |=> vblank_begin_out)
    else $error("vertical blanking did not begin on its line");

  a_htotal_msb: assert property (
    ##1 (htotal_out == {$past(st_r.ext_htotal_top_bit[0]), $past(st_r.base_horizontal_total)}))
    else $error("horizontal total top bit wrong");

  a_read_only_answer: assert property (
    !any_rd |=> !rvalid_out)
    else $error("read answer without a matching read");

  a_mode_follow: assert property (
    ##1 (ext_mode_out == $past(st_r.crtc_io_control[0])))
    else $error("extended mode flag does not follow io control");

endmodule // crtcx_timing_regs

// File: bench/crtcx_host_model.sv
// Host processor model issuing indexed register accesses
`timescale 1ns/1ps
module crtcx_host_model (
  input  wire logic        clk_in,
  input  wire logic [7:0]  rdata_in,
  input  wire logic        rvalid_in,
  output logic             colour_emulation_out,
  output logic             mem_space_out,
  output logic [15:0]      addr_out,
  output logic             wr_out,
  output logic             rd_out,
  output logic [7:0]       wdata_out
);
  initial begin
    colour_emulation_out = 1'b1;
    mem_space_out        = 1'b0;
    addr_out             = 16'hFFFF;
    wr_out               = 1'b0;
    rd_out               = 1'b0;
    wdata_out            = 8'h00;
  end

  // Caller sits just after a falling edge
  task automatic set_mode(input logic colour, input logic mem);
    colour_emulation_out <= colour;
    mem_space_out        <= mem;
    @(negedge clk_in);
  endtask

  // One idle cycle between accesses so no strobe is lowered and raised in one step
  task automatic access(input logic [15:0] addr, input logic write, input logic [7:0] data,
                        output logic [7:0] rdata, output logic rvalid);
    addr_out  <= addr;
    wr_out    <= write;
    rd_out    <= ~write;
    wdata_out <= data;
    @(negedge clk_in);
    rdata  = rdata_in;
    rvalid = rvalid_in;
    // Released lines show the inverse so a stale value cannot pass
    addr_out  <= ~addr;
    wdata_out <= ~data;
    wr_out    <= 1'b0;
    rd_out    <= 1'b0;
    @(negedge clk_in);
  endtask
endmodule // crtcx_host_model

// File: bench/tb_top.sv
// Self-checking bench for the extended timing register block
`timescale 1ns/1ps
module tb_top;
  import crtcx_pkg::*;
  logic        clk_in, rst_in, colour, mem, wr, rd, rvalid, ext_mode, strobe, vs_begin, vb_begin;
  logic [15:0] addr;
  logic [7:0]  wdata, rdata;
  logic [11:0] scan_line, vtotal, vdisp, vsync, vblank;
  logic [8:0]  htotal;
  logic [6:0]  hblank;
  int          n_mismatch, n_compared;

  crtcx_host_model host_u (.clk_in(clk_in), .rdata_in(rdata), .rvalid_in(rvalid),
    .colour_emulation_out(colour), .mem_space_out(mem), .addr_out(addr), .wr_out(wr),
    .rd_out(rd), .wdata_out(wdata));

  crtcx_timing_regs #(.VAL_W(12)) dut_u (.clk_in(clk_in), .rst_in(rst_in),
    .colour_emulation_in(colour), .mem_space_in(mem), .addr_in(addr), .wr_in(wr),
    .rd_in(rd), .wdata_in(wdata), .scan_line_in(scan_line), .scan_line_strobe_in(strobe),
    .rdata_out(rdata), .rvalid_out(rvalid), .ext_mode_out(ext_mode), .vtotal_out(vtotal),
    .vdisp_end_out(vdisp), .vsync_start_out(vsync), .vblank_start_out(vblank),
    .htotal_out(htotal), .hblank_end_out(hblank), .vsync_begin_out(vs_begin),
    .vblank_begin_out(vb_begin));

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk_val(input logic [11:0] got, input logic [11:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  function automatic logic [15:0] idx_a();
    if (!colour) return CRTCX_IDX_MONO_ADDR;
    return mem ? CRTCX_IDX_COLOUR_MM_ADDR : CRTCX_IDX_COLOUR_IO_ADDR;
  endfunction

  function automatic logic [15:0] data_a();
    return colour ? CRTCX_DATA_COLOUR_ADDR : CRTCX_DATA_MONO_ADDR;
  endfunction

  task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    logic       v;
    host_u.access(idx_a(), 1'b1, idx, q, v);
    host_u.access(data_a(), 1'b1, d, q, v);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp, input string what);
    logic [7:0] q;
    logic       v;
    host_u.access(idx_a(), 1'b1, idx, q, v);
    host_u.access(data_a(), 1'b0, 8'h00, q, v);
    chk_flag(v, 1'b1, "read valid");
    chk_val({4'h0, q}, {4'h0, exp}, what);
  endtask

  task automatic t_reset();
    logic [7:0] idx [7] = '{8'h30, 8'h31, 8'h32, 8'h33, 8'h35, 8'h39, 8'h80};
    foreach (idx[i]) rd_chk(idx[i], 8'h00, "reset value");
    chk_flag(ext_mode, 1'b0, "reset mode");
  endtask

  task automatic t_ports();
    logic [7:0] q;
    logic       v;
    for (int m = 0; m < 4; m++) begin
      host_u.set_mode(m[1], m[0]);
      wr_reg(CRTCX_IDX_EXT_VTOTAL, 8'h05 + 8'(m));
      rd_chk(CRTCX_IDX_EXT_VTOTAL, 8'h05 + 8'(m), "port pair");
    end
    host_u.set_mode(1'b1, 1'b0);
    host_u.access(CRTCX_IDX_COLOUR_MM_ADDR, 1'b0, 8'h00, q, v);
    chk_flag(v, 1'b0, "io 3D3 ignored");
    host_u.access(CRTCX_DATA_MONO_ADDR, 1'b0, 8'h00, q, v);
    chk_flag(v, 1'b0, "mono data in colour");
    host_u.access(data_a(), 1'b0, 8'h00, q, v);
    chk_val({4'h0, q}, 12'h008, "index kept");
  endtask

  task automatic t_masks();
    logic [7:0] idx [8] = '{8'h30, 8'h31, 8'h32, 8'h33, 8'h35, 8'h39, 8'h34, 8'h80};
    logic [7:0] exp [8] = '{8'h0F, 8'h0F, 8'h0F, 8'h0F, 8'h01, 8'h01, 8'h00, 8'h03};
    foreach (idx[i]) begin
      wr_reg(idx[i], 8'hFF);
      rd_chk(idx[i], exp[i], "write mask");
    end
    chk_flag(ext_mode, 1'b1, "ext mode on");
  endtask

  task automatic t_std(input logic [7:0] ovf, input logic [7:0] msl);
    wr_reg(CRTCX_IDX_IO_CONTROL, 8'h00);
    for (int i = 0; i < 4; i++) wr_reg(CRTCX_IDX_EXT_VTOTAL + 8'(i), 8'h0A + 8'(i));
    wr_reg(CRTCX_IDX_BASE_VTOTAL, 8'h12); // Total lines minus two
    wr_reg(CRTCX_IDX_BASE_VDISP, 8'h34); // Active lines minus one
    wr_reg(CRTCX_IDX_BASE_VSYNC, 8'h56);
    wr_reg(CRTCX_IDX_BASE_VBLANK, 8'h78);
    wr_reg(CRTCX_IDX_OVERFLOW, ovf);
    wr_reg(CRTCX_IDX_MAX_SCAN, msl);
    repeat (3) @(negedge clk_in);
    chk_val(vtotal, {2'b00, ovf[5], ovf[0], 8'h12}, "std vtotal");
    chk_val(vdisp, {2'b00, ovf[6], ovf[1], 8'h34}, "std vdisp");
    chk_val(vsync, {2'b00, ovf[7], ovf[2], 8'h56}, "std vsync");
    chk_val(vblank, {2'b00, msl[5], ovf[3], 8'h78}, "std vblank");
  endtask

  task automatic t_ext();
    wr_reg(CRTCX_IDX_IO_CONTROL, 8'h01);
    wr_reg(CRTCX_IDX_BASE_HTOTAL, 8'hC3);
    wr_reg(CRTCX_IDX_EXT_HTOTAL, 8'h01); // Upper bits kept zero
    wr_reg(CRTCX_IDX_HRETRACE_END, 8'h80);
    wr_reg(CRTCX_IDX_HBLANK_END, 8'hF5);
    wr_reg(CRTCX_IDX_EXT_HBLANK, 8'h01);
    repeat (3) @(negedge clk_in);
    chk_val(vtotal, 12'hA12, "ext vtotal");
    chk_val(vdisp, 12'hB34, "ext vdisp");
    chk_val(vsync, 12'hC56, "ext vsync");
    chk_val(vblank, 12'hD78, "ext vblank");
    chk_val({3'b000, htotal}, 12'h1C3, "htotal");
    chk_val({5'b00000, hblank}, 12'h075, "hblank end");
  endtask

  task automatic scan(input logic [11:0] line, input logic exp_sync, input logic exp_blank);
    scan_line <= line;
    strobe    <= 1'b1;
    @(negedge clk_in);
    scan_line <= ~line;
    strobe    <= 1'b0;
    chk_flag(vs_begin, exp_sync, "vsync begin");
    chk_flag(vb_begin, exp_blank, "vblank begin");
    @(negedge clk_in);
    chk_flag(vs_begin | vb_begin, 1'b0, "pulse length");
  endtask

  task automatic t_protect();
    wr_reg(CRTCX_IDX_VRETRACE_END, 8'h80);
    wr_reg(CRTCX_IDX_BASE_HTOTAL, 8'h11);
    wr_reg(CRTCX_IDX_BASE_VTOTAL, 8'h99);
    wr_reg(CRTCX_IDX_OVERFLOW, 8'h00);
    wr_reg(CRTCX_IDX_BASE_VSYNC, 8'h57);
    rd_chk(CRTCX_IDX_BASE_HTOTAL, 8'hC3, "protect idx 0");
    rd_chk(CRTCX_IDX_BASE_VTOTAL, 8'h12, "protect idx 6");
    rd_chk(CRTCX_IDX_OVERFLOW, 8'h96, "protect idx 7");
    rd_chk(CRTCX_IDX_BASE_VSYNC, 8'h57, "unprotected");
    wr_reg(CRTCX_IDX_VRETRACE_END, 8'h00);
    wr_reg(CRTCX_IDX_BASE_VTOTAL, 8'h99);
    rd_chk(CRTCX_IDX_BASE_VTOTAL, 8'h99, "unlocked");
  endtask

  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  // Whole run needs about 320 cycles
  initial begin
    repeat (5000) @(posedge clk_in);
    n_mismatch++;
    end_sim();
  end

  initial begin
    rst_in     = 1'b1;
    scan_line  = 12'h000;
    strobe     = 1'b0;
    n_mismatch = 0;
    n_compared = 0;
    repeat (4) @(posedge clk_in);
    @(negedge clk_in);
    rst_in = 1'b0;
    t_reset();
    t_ports();
    t_masks();
    t_std(8'h69, 8'h20);
    t_std(8'h96, 8'h00);
    t_ext();
    scan(12'hC56, 1'b1, 1'b0);
    scan(12'hC55, 1'b0, 1'b0);
    scan(12'h056, 1'b0, 1'b0);
    scan(12'hD78, 1'b0, 1'b1);
    t_protect();
    end_sim();
  end
endmodule // tb_top
